// file: design/asc_defines.svh
// constants for the serial control byte decoder of the converter
`ifndef ASC_DEFINES_SVH
`define ASC_DEFINES_SVH

// ************************************************************
// control byte field positions
// ************************************************************
`define ASC_CMD_START_BIT 7
`define ASC_CMD_SEL_HI 6
`define ASC_CMD_SEL_MID 5
`define ASC_CMD_SEL_LO 4
`define ASC_CMD_POL 3
`define ASC_CMD_CFG 2
`define ASC_CMD_MODE_HI 1
`define ASC_CMD_MODE_LO 0

// ************************************************************
// reset values and bit counts
// ************************************************************
`define ASC_CMD_RESET 8'h00
`define ASC_RES_RESET 12'h000
`define ASC_CMD_BITS 4'h8
`define ASC_RESULT_BITS 4'hc

// ************************************************************
// internal conversion timing
// ************************************************************
`define ASC_INT_CONV_NS 10000
`define ASC_MCLK_NS 50
`define ASC_INT_CONV_CYC ((`ASC_INT_CONV_NS) / (`ASC_MCLK_NS))

`endif

// file: design/asc_pkg.sv
// types shared by the serial control byte decoder
package asc_pkg;

    // sequencer states, gray coded along wait-cmd-strobe-data
    typedef enum logic [2:0] {
        ST_WAIT  = 3'h0,
        ST_CMD   = 3'h1,
        ST_STRB  = 3'h3,
        ST_DATA  = 3'h2,
        ST_ICONV = 3'h6,
        ST_IRDY  = 3'h7
    } asc_state_type;

    // clock and power-down modes from the two mode bits
    typedef enum logic [1:0] {
        MODE_FULL_PD = 2'h0,
        MODE_FAST_PD = 2'h1,
        MODE_INT_CLK = 2'h2,
        MODE_EXT_CLK = 2'h3
    } asc_mode_type;

endpackage

// file: design/asc_sync2.sv
// two flip-flop synchroniser for one pin input
`timescale 1ns/1ps

module asc_sync2 (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic rst_val,
    input wire logic d,
    output logic q
);
    logic meta_q;
    logic meta_d;
    logic q_d;

    // first stage feeds only the second
    always_comb begin
        meta_d = d;
        q_d = meta_q;
    end

    // both stages load the idle level under reset
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            meta_q <= rst_val;
            q <= rst_val;
        end else begin
            meta_q <= meta_d;
            q <= q_d;
        end
    end
endmodule

// file: design/asc_ctrl_top.sv
// serial control byte front end and result shifter of the converter
`timescale 1ns/1ps
`include "asc_defines.svh"

module asc_ctrl_top (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic [11:0] adc_code,
    output logic dout,
    output logic dout_oe,
    output logic conversion_strobe,
    output logic strobe_oe,
    output logic [2:0] pos_chan,
    output logic [2:0] neg_chan,
    output logic neg_is_gnd,
    output logic polarity_sel,
    output logic input_config_sel,
    output asc_pkg::asc_mode_type conv_mode,
    output logic conv_start,
    output logic powered_down
);
    import asc_pkg::*;

    // ************************************************************
    // pin synchronisers and serial clock edges
    // ************************************************************
    logic cs_s;
    logic sclk_s;
    logic din_s;
    logic sclk_p_q;
    logic sck_rise;
    logic sck_fall;

    asc_sync2 u_sync_cs (.mclk(mclk), .rstn(rstn), .rst_val(1'b0), .d(~cs_n), .q(cs_s));
    asc_sync2 u_sync_sclk (.mclk(mclk), .rstn(rstn), .rst_val(1'b0), .d(sclk), .q(sclk_s));
    asc_sync2 u_sync_din (.mclk(mclk), .rstn(rstn), .rst_val(1'b0), .d(din), .q(din_s));

    // cs_s is the selected level (active high after inversion)
    assign sck_rise = sclk_s & ~sclk_p_q;
    assign sck_fall = ~sclk_s & sclk_p_q;

    // ************************************************************
    // sequencer state
    // ************************************************************
    asc_state_type state_q, state_d;
    logic [7:0] cmd_q, cmd_d;
    logic [7:0] conversion_command_byte_q, conversion_command_byte_d;
    logic [3:0] cnt_q, cnt_d;
    logic full_q, full_d;
    logic [11:0] res_q, res_d;
    logic [7:0] icnt_q, icnt_d;
    logic dout_d, dout_oe_d, strobe_d, strobe_oe_d;
    logic [2:0] pos_d, neg_d;
    logic gnd_d, uni_d, sgl_d, start_d, pd_d;
    asc_mode_type mode_d;

    // fields of the byte sitting in the shift register
    logic chan_sel_hi, chan_sel_mid, chan_sel_lo;
    logic polarity_bit, input_config_bit, mode_bit_hi, mode_bit_lo;

    assign chan_sel_hi = cmd_q[`ASC_CMD_SEL_HI];
    assign chan_sel_mid = cmd_q[`ASC_CMD_SEL_MID];
    assign chan_sel_lo = cmd_q[`ASC_CMD_SEL_LO];
    assign polarity_bit = cmd_q[`ASC_CMD_POL];
    assign input_config_bit = cmd_q[`ASC_CMD_CFG];
    assign mode_bit_hi = cmd_q[`ASC_CMD_MODE_HI];
    assign mode_bit_lo = cmd_q[`ASC_CMD_MODE_LO];

    // next state of the whole serial sequencer
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        conversion_command_byte_d = conversion_command_byte_q;
        cnt_d = cnt_q;
        full_d = full_q;
        res_d = res_q;
        icnt_d = icnt_q;
        dout_d = dout;
        strobe_d = conversion_strobe;
        pos_d = pos_chan;
        neg_d = neg_chan;
        gnd_d = neg_is_gnd;
        uni_d = polarity_sel;
        sgl_d = input_config_sel;
        mode_d = conv_mode;
        start_d = 1'b0;
        pd_d = powered_down;
        // data out floats while deselected
        dout_oe_d = cs_s;
        // strobe keeps driving in internal clock mode
        strobe_oe_d = cs_s | (conv_mode == MODE_INT_CLK);
        unique case (state_q)
            ST_WAIT: begin
                // an idle fall retires a strobe left high by a finished readout
                if (cs_s && sck_fall) begin
                    strobe_d = 1'b0;
                end
                // zeros are skipped, first one opens the byte
                if (cs_s && sck_rise && din_s) begin
                    cmd_d = {7'h00, 1'b1};
                    cnt_d = 4'h1;
                    full_d = 1'b0;
                    pd_d = 1'b0;
                    state_d = ST_CMD;
                end
            end
            ST_CMD: begin
                if (!cs_s) begin
                    // partial byte dropped, nothing starts
                    full_d = 1'b0;
                    cnt_d = 4'h0;
                    state_d = ST_WAIT;
                end else if (sck_rise && !full_q) begin
                    // one bit per rising edge
                    cmd_d = {cmd_q[6:0], din_s};
                    cnt_d = cnt_q + 4'h1;
                    full_d = (cnt_q == (`ASC_CMD_BITS - 4'h1));
                end else if (sck_fall && full_q) begin
                    // decode on the fall after the eighth bit
                    conversion_command_byte_d = cmd_q;
                    // positive input is mid, lo, hi in both configurations
                    pos_d = {chan_sel_mid, chan_sel_lo, chan_sel_hi};
                    // negative is ground or the other pair member
                    neg_d = {chan_sel_mid, chan_sel_lo, ~chan_sel_hi};
                    gnd_d = input_config_bit;
                    uni_d = polarity_bit;
                    sgl_d = input_config_bit;
                    mode_d = asc_mode_type'({mode_bit_hi, mode_bit_lo});
                    // unipolar as is, bipolar msb flipped to two's complement
                    res_d = polarity_bit ? adc_code : {~adc_code[11], adc_code[10:0]};
                    full_d = 1'b0;
                    cnt_d = 4'h0;
                    // leading zero ahead of the result
                    dout_d = 1'b0;
                    start_d = 1'b1;
                    // mode bits choose the conversion path
                    unique case ({mode_bit_hi, mode_bit_lo})
                        MODE_EXT_CLK: begin
                            // strobe rises on this falling edge
                            strobe_d = 1'b1;
                            state_d = ST_STRB;
                        end
                        MODE_INT_CLK: begin
                            strobe_d = 1'b0;
                            icnt_d = 8'(`ASC_INT_CONV_CYC);
                            state_d = ST_ICONV;
                        end
                        MODE_FULL_PD, MODE_FAST_PD: begin
                            pd_d = 1'b1;
                            state_d = ST_WAIT;
                        end
                    endcase
                end
            end
            ST_STRB: begin
                if (!cs_s) begin
                    strobe_d = 1'b0;
                    state_d = ST_WAIT;
                end else if (sck_fall) begin
                    // one serial period later strobe drops and msb appears
                    strobe_d = 1'b0;
                    dout_d = res_q[11];
                    res_d = {res_q[10:0], 1'b0};
                    cnt_d = 4'h1;
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (!cs_s) begin
                    cnt_d = 4'h0;
                    state_d = ST_WAIT;
                end else if (sck_fall) begin
                    // each falling edge paces one result bit, then zeros
                    if (cnt_q < `ASC_RESULT_BITS) begin
                        dout_d = res_q[11];
                        res_d = {res_q[10:0], 1'b0};
                        cnt_d = cnt_q + 4'h1;
                    end else begin
                        dout_d = 1'b0;
                        cnt_d = 4'h0;
                        state_d = ST_WAIT;
                    end
                end
            end
            ST_ICONV: begin
                // internal clock conversion runs on without select
                if (icnt_q <= 8'h1) begin
                    icnt_d = 8'h0;
                    strobe_d = 1'b1;
                    state_d = ST_IRDY;
                end else begin
                    icnt_d = icnt_q - 8'h1;
                end
            end
            ST_IRDY: begin
                // result waits for the host's next falling edge
                if (cs_s && sck_fall) begin
                    dout_d = res_q[11];
                    res_d = {res_q[10:0], 1'b0};
                    cnt_d = 4'h1;
                    state_d = ST_DATA;
                end
            end
            default: begin
                state_d = ST_WAIT;
            end
        endcase
    end

    // registers of the sequencer and every output
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            sclk_p_q <= 1'b0;
            state_q <= ST_WAIT;
            cmd_q <= `ASC_CMD_RESET;
            conversion_command_byte_q <= `ASC_CMD_RESET;
            cnt_q <= 4'h0;
            full_q <= 1'b0;
            res_q <= `ASC_RES_RESET;
            icnt_q <= 8'h0;
            dout <= 1'b0;
            dout_oe <= 1'b0;
            conversion_strobe <= 1'b0;
            strobe_oe <= 1'b0;
            pos_chan <= 3'h0;
            neg_chan <= 3'h1;
            neg_is_gnd <= 1'b0;
            polarity_sel <= 1'b0;
            input_config_sel <= 1'b0;
            conv_mode <= MODE_FULL_PD;
            conv_start <= 1'b0;
            powered_down <= 1'b0;
        end else begin
            sclk_p_q <= sclk_s;
            state_q <= state_d;
            cmd_q <= cmd_d;
            conversion_command_byte_q <= conversion_command_byte_d;
            cnt_q <= cnt_d;
            full_q <= full_d;
            res_q <= res_d;
            icnt_q <= icnt_d;
            dout <= dout_d;
            dout_oe <= dout_oe_d;
            conversion_strobe <= strobe_d;
            strobe_oe <= strobe_oe_d;
            // decoded fields only move at decode time
            pos_chan <= pos_d;
            neg_chan <= neg_d;
            neg_is_gnd <= gnd_d;
            polarity_sel <= uni_d;
            input_config_sel <= sgl_d;
            conv_mode <= mode_d;
            conv_start <= start_d;
            powered_down <= pd_d;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // strobe period followed by msb on the next fall
    sequence s_strobe_fall;
        (state_q == ST_STRB) && cs_s && sck_fall;
    endsequence
    sequence s_msb_out;
        !conversion_strobe && (state_q == ST_DATA) && (cnt_q == 4'h1);
    endsequence

    a_bit_capture: assert property ((state_q == ST_CMD) && cs_s && sck_rise && !full_q |=>
        cmd_q[0] == $past(din_s) && cnt_q == $past(cnt_q) + 4'h1)
        else $error("bit not captured on rising edge");
    a_zero_skipped: assert property ((state_q == ST_WAIT) && sck_rise && !din_s |=>
        state_q == ST_WAIT)
        else $error("leading zero opened a byte");
    a_start_opens: assert property ((state_q == ST_WAIT) && cs_s && sck_rise && din_s |=>
        state_q == ST_CMD && cmd_q == 8'h01)
        else $error("start bit not taken");
    a_chan_map: assert property ($rose(conv_start) |->
        pos_chan == {$past(cmd_q[5]), $past(cmd_q[4]), $past(cmd_q[6])})
        else $error("positive channel wrongly decoded");
    a_pair_neg: assert property (conv_start && !input_config_sel |->
        neg_chan == {pos_chan[2:1], ~pos_chan[0]} && !neg_is_gnd)
        else $error("differential pair member wrong");
    a_mode_decode: assert property ($rose(conv_start) |->
        conv_mode == asc_mode_type'($past(cmd_q[1:0])) && polarity_sel == $past(cmd_q[3]) &&
        conversion_command_byte_q == $past(cmd_q))
        else $error("mode or polarity wrongly decoded");
    a_start_on_fall: assert property ($rose(conv_start) |->
        $past(sck_fall) && $past(full_q) && $past(state_q) == ST_CMD)
        else $error("conversion started at wrong moment");
    a_fields_hold: assert property ($changed(pos_chan) || $changed(conv_mode) |-> conv_start)
        else $error("decoded field moved without a new byte");
    a_strobe_msb: assert property (s_strobe_fall |=> s_msb_out ##0 dout == $past(res_q[11]))
        else $error("msb not after strobe period");
    a_strobe_fall: assert property ($changed(conversion_strobe) && !$past(!cs_s) &&
        conv_mode == MODE_EXT_CLK |-> $past(sck_fall))
        else $error("strobe moved off a falling edge");
    a_dout_fall: assert property ($changed(dout) |-> $past(sck_fall))
        else $error("data out moved off a falling edge");
    a_bipolar_code: assert property ($rose(conv_start) && !polarity_sel |->
        res_q == {~$past(adc_code[11]), $past(adc_code[10:0])})
        else $error("bipolar result not two's complement");
    a_trailing_zero: assert property ((state_q == ST_DATA) && cs_s && sck_fall &&
        cnt_q == `ASC_RESULT_BITS |=> !dout && state_q == ST_WAIT)
        else $error("no zero after last result bit");
endmodule

// file: verif/asc_spi_master.sv
// serial master model that drives the converter's command pins
`timescale 1ns/1ps

module asc_spi_master (
    output logic cs_n,
    output logic sclk,
    output logic din,
    input wire logic dout,
    input wire logic dout_oe,
    input wire logic conversion_strobe,
    input wire logic strobe_oe
);
    logic dout_pin;
    logic strobe_pin;

    // undriven pins read as the inverse of the last value
    assign dout_pin = dout_oe ? dout : ~dout;
    assign strobe_pin = strobe_oe ? conversion_strobe : ~conversion_strobe;

    // ************************************************************
    // idle pins and framed transfer
    // ************************************************************
    // idle: clock low, select high
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0; // clock idles low
        din = 1'b0;
    end

    // n bits msb first, data and strobe sampled mid high phase
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx, output logic [31:0] stb);
        rx = 32'h0;
        stb = 32'h0;
        cs_n = 1'b0;
        #200;
        for (int i = n - 1; i >= 0; i--) begin
            din = tx[i]; // full duplex, fresh command per conversion
            #200 sclk = 1'b1; // data taken on the first edge
            #100 rx[i] = dout_pin;
            stb[i] = strobe_pin;
            #100 sclk = 1'b0;
        end
        // select held past the last fall so that fall is still seen
        #200 cs_n = 1'b1;
        din = ~din; // released line keeps changing
        #400;
    endtask
endmodule

// file: verif/asc_ctrl_top_test.sv
// self-checking bench for the serial control byte decoder
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module asc_ctrl_top_test;
    import asc_pkg::*;
    logic mclk, rstn, cs_n, sclk, din, dout, dout_oe, conversion_strobe, strobe_oe;
    logic neg_is_gnd, polarity_sel, input_config_sel, conv_start, powered_down;
    logic [11:0] adc_code;
    logic [2:0] pos_chan, neg_chan;
    asc_mode_type conv_mode;
    int errors = 0;
    int num_checks = 0;
    int starts = 0;

    asc_ctrl_top asc_ctrl_top_inst (.mclk(mclk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .din(din),
        .adc_code(adc_code), .dout(dout), .dout_oe(dout_oe), .conversion_strobe(conversion_strobe),
        .strobe_oe(strobe_oe), .pos_chan(pos_chan), .neg_chan(neg_chan), .neg_is_gnd(neg_is_gnd),
        .polarity_sel(polarity_sel), .input_config_sel(input_config_sel), .conv_mode(conv_mode),
        .conv_start(conv_start), .powered_down(powered_down));
    asc_spi_master asc_spi_master_inst (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout),
        .dout_oe(dout_oe), .conversion_strobe(conversion_strobe), .strobe_oe(strobe_oe));

    // ************************************************************
    // clock, start counter, closing
    // ************************************************************
    // system clock, 50 ns period
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // counts conversion launches
    always @(negedge mclk) begin
        if (conv_start === 1'b1) starts++;
    end

    task automatic stop_test;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    // external clock conversion, lead leading zeros before the start bit
    task automatic ext_case(input logic [7:0] cmd, input logic [11:0] code, input int lead);
        logic [31:0] rx, stb;
        int s0;
        @(negedge mclk) adc_code = code;
        s0 = starts;
        asc_spi_master_inst.xfer(24 + lead, {8'h00, cmd, 16'h0000}, rx, stb);
        `CHK(pos_chan, {cmd[5:4], cmd[6]})
        if (!cmd[2]) `CHK(neg_chan, {cmd[5:4], ~cmd[6]})
        `CHK(neg_is_gnd, cmd[2])
        `CHK(input_config_sel, cmd[2])
        `CHK(polarity_sel, cmd[3])
        `CHK(conv_mode, MODE_EXT_CLK)
        `CHK(powered_down, 1'b0)
        `CHK(starts - s0, 1)
        `CHK(rx[15:0], {1'b0, (cmd[3] ? code : code ^ 12'h800), 3'b000})
        `CHK(stb[23:0], 24'h008000)
        $display("ext case cmd=%h done", cmd);
    endtask

    // power-down modes decode with a conv_start pulse but no strobe
    task automatic pd_case(input logic [1:0] mode);
        logic [31:0] rx, stb;
        asc_spi_master_inst.xfer(8, {24'h0, 1'b1, 3'h5, 2'b10, mode}, rx, stb);
        `CHK(conv_mode, mode)
        `CHK(pos_chan, 3'h3)
        `CHK(powered_down, 1'b1)
        `CHK(stb[7:0], 8'h00)
        $display("power-down case mode=%h done", mode);
    endtask

    // byte dropped by select rising mid-byte, then zeros only
    task automatic abort_case;
        logic [31:0] rx, stb;
        logic [2:0] chan;
        asc_mode_type mode;
        int s0;
        chan = pos_chan;
        mode = conv_mode;
        s0 = starts;
        asc_spi_master_inst.xfer(5, 32'h1f, rx, stb);
        asc_spi_master_inst.xfer(8, 32'h0, rx, stb);
        `CHK(starts - s0, 0)
        `CHK(pos_chan, chan)
        `CHK(conv_mode, mode)
        $display("abort case done");
    endtask

    // internal clock conversion with select released meanwhile
    task automatic int_case(input logic [11:0] code);
        logic [31:0] rx, stb;
        @(negedge mclk) adc_code = code;
        asc_spi_master_inst.xfer(8, 32'hc2, rx, stb);
        repeat (40) @(negedge mclk);
        `CHK(strobe_oe, 1'b1)
        `CHK(conversion_strobe, 1'b0)
        `CHK(pos_chan, 3'h1)
        `CHK(neg_chan, 3'h0)
        repeat (200) @(negedge mclk);
        `CHK(conversion_strobe, 1'b1)
        asc_spi_master_inst.xfer(16, 32'h0, rx, stb);
        `CHK(rx[14:0], {code ^ 12'h800, 3'b000})
        `CHK(conv_mode, MODE_INT_CLK)
        $display("internal case done");
    endtask

    // ************************************************************
    // main sequence and watchdog
    // ************************************************************
    initial begin
        rstn = 1'b0;
        adc_code = 12'h000;
        repeat (8) @(negedge mclk);
        rstn = 1'b1;
        repeat (8) @(negedge mclk);
        for (int i = 0; i < 16; i++) begin
            ext_case({1'b1, i[2:0], i[0] ~^ i[3], i[3], 2'b11}, 12'h9a5 + 12'(i * 273), 0);
        end
        ext_case(8'hff, 12'hfff, 0);
        ext_case(8'hb7, 12'h001, 3);
        pd_case(2'h0);
        pd_case(2'h1);
        ext_case(8'h8b, 12'h800, 1);
        abort_case();
        int_case(12'h3c6);
        ext_case(8'hf3, 12'h000, 0);
        stop_test();
    end

    // cuts a hang short
    initial begin
        #500000;
        errors++;
        stop_test();
    end
endmodule
